/* hw/dprx_rx_port.v */
// Receive data register bank of the demodulator, APB slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "dprx_defines.vh"
module dprx_rx_port (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg irq_n,
    input wire pkt_wr_en,
    input wire pkt_wr_sub,
    input wire [5:0] pkt_wr_addr,
    input wire [7:0] pkt_wr_data,
    input wire pkt_done,
    input wire pkt_done_sub,
    input wire post_fix_crc_error,
    input wire fix_result_error,
    input wire raw_crc_error,
    input wire frame_lock_flag,
    input wire block_lock_flag,
    input wire block_id_found,
    input wire block_id_hi,
    input wire block_id_lo,
    input wire traffic_service_flag,
    input wire parity_packet,
    input wire segment_boundary_flag,
    input wire segment_index_hi,
    input wire segment_index_lo,
    input wire real_packet,
    input wire si_match,
    input wire timer_main_evt,
    input wire timer_sub_evt,
    input wire sync_lost_evt,
    input wire frame_pkt_strobe,
    input wire frame_first,
    input wire frame_last,
    input wire fix2_update,
    input wire [7:0] fix2_result,
    output reg vfix_start,
    output wire [14:0] fm_addr,
    output reg fm_we,
    output reg [7:0] fm_wdata,
    input wire [7:0] fm_rdata
);
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    reg ack_q;
    reg [7:0] stat_q;
    reg [7:0] stat_d;
    reg [7:0] mask_q;
    reg sub_sel_q;
    reg [7:0] cond_q;
    reg [7:0] mode_q;
    reg [7:0] fix2_q;
    reg [5:0] rd_ptr_q;
    reg [7:0] main_s0_q;
    reg [7:0] main_s1_q;
    reg [7:0] sub_s0_q;
    reg [7:0] sub_s1_q;
    reg [8:0] frm_cnt_q;
    reg frame_full_q;
    reg frame_pend_q;
    wire [5:0] idx;
    wire hit;
    wire done;
    wire wr_done;
    wire rd_done;
    wire [7:0] wbyte;
    wire [7:0] main_q;
    wire [7:0] sub_q;
    wire [8:0] fm_pkt;
    wire [5:0] fm_byte;

    assign idx = paddr[7:2];
    assign wbyte = pwdata[7:0];

    assign hit = (idx == `DPRX_IDX_STAT) || (idx == `DPRX_IDX_MASK) ||
                 (idx == `DPRX_IDX_BSEL) || (idx == `DPRX_IDX_PKT) ||
                 (idx == `DPRX_IDX_COND) || (idx == `DPRX_IDX_FIX2) ||
                 (idx == `DPRX_IDX_FRM) || (idx == `DPRX_IDX_MODE) ||
                 (idx == `DPRX_IDX_PTR_LO) || (idx == `DPRX_IDX_PTR_HI) ||
                 (idx == `DPRX_IDX_PTR_BYTE);

    // One wait state gives the buffers time to present registered data
    assign pready = psel & penable & ack_q;
    assign pslverr = pready & ~hit;
    assign done = pready;
    assign wr_done = done & pwrite & hit;
    assign rd_done = done & ~pwrite & hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= psel & penable & ~ack_q;
        end
    end

    // ----------------------------------------------------------------
    // Packet interrupt qualification
    // ----------------------------------------------------------------
    wire pkt_bad;
    wire pkt_ok;
    wire early_irq_tag;
    wire main_irq;
    wire sub_irq;

    assign pkt_bad = post_fix_crc_error | fix_result_error;
    assign pkt_ok = (~cond_q[`DPRX_COND_GOOD] | ~pkt_bad) &
                    (~cond_q[`DPRX_COND_NOPAR] | ~parity_packet) &
                    (~cond_q[`DPRX_COND_SI] | si_match);
    assign early_irq_tag = pkt_ok;
    assign main_irq = pkt_done & ~pkt_done_sub & pkt_ok;
    assign sub_irq = pkt_done & pkt_done_sub & pkt_ok;

    // ----------------------------------------------------------------
    // Packet status bytes
    // ----------------------------------------------------------------
    wire [7:0] s0_d;
    wire [7:0] s1_d;

    assign s0_d = {post_fix_crc_error, fix_result_error, raw_crc_error,
                   frame_lock_flag, block_lock_flag,
                   block_id_found,
                   block_id_found & block_id_hi,
                   block_id_found & block_id_lo};
    // Lock-only fields read as zero outside frame lock
    assign s1_d = {traffic_service_flag,
                   frame_lock_flag & parity_packet,
                   early_irq_tag, 2'b00,
                   frame_lock_flag & segment_boundary_flag,
                   frame_lock_flag & segment_index_hi,
                   frame_lock_flag & segment_index_lo};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_s0_q <= `DPRX_RST8;
            main_s1_q <= `DPRX_RST8;
            sub_s0_q <= `DPRX_RST8;
            sub_s1_q <= `DPRX_RST8;
        end else if (pkt_done) begin
            if (pkt_done_sub) begin
                sub_s0_q <= s0_d;
                sub_s1_q <= s1_d;
            end else begin
                main_s0_q <= s0_d;
                main_s1_q <= s1_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Packet buffers
    // ----------------------------------------------------------------
    wire test_wr;
    wire main_we;
    wire sub_we;
    wire [5:0] ram_waddr;
    wire [7:0] ram_wdata;

    // Test writes lose to the live packet stream
    assign test_wr = wr_done & (idx == `DPRX_IDX_PKT) & ~pkt_wr_en;
    assign main_we = pkt_wr_en ? ~pkt_wr_sub : (test_wr & ~sub_sel_q);
    assign sub_we = pkt_wr_en ? pkt_wr_sub : (test_wr & sub_sel_q);
    assign ram_waddr = pkt_wr_en ? pkt_wr_addr : rd_ptr_q;
    assign ram_wdata = pkt_wr_en ? pkt_wr_data : wbyte;

    dprx_pkt_ram u_main_packet_ram (
        .pclk(pclk),
        .presetn(presetn),
        .we(main_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(rd_ptr_q),
        .rdata(main_q)
    );

    dprx_pkt_ram u_second_packet_ram (
        .pclk(pclk),
        .presetn(presetn),
        .we(sub_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(rd_ptr_q),
        .rdata(sub_q)
    );

    // ----------------------------------------------------------------
    // Packet read pointer
    // ----------------------------------------------------------------
    wire pkt_access;

    assign pkt_access = done & (idx == `DPRX_IDX_PKT);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= `DPRX_PTR_RST;
        end else if (main_irq || sub_irq) begin
            rd_ptr_q <= `DPRX_PTR_RST;
        end else if (wr_done && idx == `DPRX_IDX_BSEL) begin
            rd_ptr_q <= `DPRX_PTR_RST;
        end else if (pkt_access && rd_ptr_q < `DPRX_PKT_LAST) begin
            // Stops at the last data byte; trailer is never reached
            rd_ptr_q <= rd_ptr_q + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `DPRX_RST8;
            sub_sel_q <= 1'b0;
            cond_q <= `DPRX_RST8;
            mode_q <= `DPRX_RST8;
        end else if (wr_done) begin
            if (idx == `DPRX_IDX_MASK) begin
                mask_q <= wbyte & `DPRX_MASK_BITS;
            end else if (idx == `DPRX_IDX_BSEL) begin
                sub_sel_q <= wbyte[0];
            end else if (idx == `DPRX_IDX_COND) begin
                cond_q <= wbyte;
            end else if (idx == `DPRX_IDX_MODE) begin
                mode_q <= wbyte;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fix2_q <= `DPRX_RST8;
        end else if (fix2_update && frame_lock_flag) begin
            fix2_q <= fix2_result;
        end
    end

    // ----------------------------------------------------------------
    // Frame tracking
    // ----------------------------------------------------------------
    wire [8:0] frm_cnt_d;
    wire [8:0] frm_target;
    wire frame_irq;

    assign frm_cnt_d = frame_first ? 9'h001 : frm_cnt_q + 9'h001;
    assign frm_target = cond_q[`DPRX_COND_PARTEST] ?
                        `DPRX_FRAME_IRQ_TEST : `DPRX_FRAME_IRQ_PKT;
    assign frame_irq = frame_pkt_strobe & frame_pend_q &
                       (frm_cnt_d == frm_target);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_cnt_q <= 9'h000;
            frame_full_q <= 1'b0;
            frame_pend_q <= 1'b0;
            vfix_start <= 1'b0;
        end else begin
            vfix_start <= frame_pkt_strobe & frame_last & frame_full_q &
                          ~sync_lost_evt;
            if (frame_pkt_strobe && frm_cnt_q != 9'h1ff) begin
                frm_cnt_q <= frm_cnt_d;
            end
            // A frame joined mid-way never counts as complete
            if (sync_lost_evt) begin
                frame_full_q <= 1'b0;
            end else if (frame_pkt_strobe && frame_first) begin
                frame_full_q <= 1'b1;
            end
            if (sync_lost_evt) begin
                frame_pend_q <= 1'b0;
            end else if (frame_pkt_strobe && frame_last) begin
                frame_pend_q <= 1'b1;
            end else if (frame_irq) begin
                frame_pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flags, set wins over write-one-to-clear
    // ----------------------------------------------------------------
    wire [7:0] flag_set;
    wire [7:0] flag_clr;

    assign flag_set = {sub_irq, timer_sub_evt, timer_main_evt, frame_irq,
                       1'b0, sync_lost_evt, main_irq,
                       main_irq & real_packet};
    assign flag_clr = (wr_done && idx == `DPRX_IDX_STAT) ?
                      {wbyte[7:1] & `DPRX_MASK_BITS_HI, wbyte[`DPRX_B_MAIN]} :
                      8'h00;

    always @* begin
        stat_d = (stat_q & ~flag_clr) | flag_set;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= `DPRX_RST8;
            irq_n <= 1'b1;
        end else begin
            stat_q <= stat_d;
            irq_n <= ~|(stat_d & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Frame memory port
    // ----------------------------------------------------------------
    wire frm_access;

    assign frm_access = done & (idx == `DPRX_IDX_FRM);
    assign fm_addr = {fm_pkt, fm_byte};

    dprx_frame_ptr u_frame_ptr (
        .pclk(pclk),
        .presetn(presetn),
        .ld_pkt_lo(wr_done & (idx == `DPRX_IDX_PTR_LO)),
        .ld_pkt_hi(wr_done & (idx == `DPRX_IDX_PTR_HI)),
        .ld_byte(wr_done & (idx == `DPRX_IDX_PTR_BYTE)),
        .wdata(wbyte),
        .step(frm_access),
        .vert(mode_q[`DPRX_MODE_VERT]),
        .parity(mode_q[`DPRX_MODE_PARITY]),
        .pkt_q(fm_pkt),
        .byte_q(fm_byte)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fm_we <= 1'b0;
            fm_wdata <= `DPRX_RST8;
        end else begin
            fm_we <= frm_access & pwrite;
            if (frm_access && pwrite) begin
                fm_wdata <= wbyte;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data, captured in the first access cycle
    // ----------------------------------------------------------------
    reg [7:0] rd_mux;
    reg [7:0] pkt_byte;

    always @* begin
        if (rd_ptr_q == `DPRX_PTR_RST) begin
            pkt_byte = sub_sel_q ? sub_s0_q : main_s0_q;
        end else if (rd_ptr_q == `DPRX_PKT_STAT1) begin
            pkt_byte = sub_sel_q ? sub_s1_q : main_s1_q;
        end else begin
            pkt_byte = sub_sel_q ? sub_q : main_q;
        end
    end

    always @* begin
        if (idx == `DPRX_IDX_STAT) begin
            rd_mux = stat_q;
        end else if (idx == `DPRX_IDX_PKT) begin
            rd_mux = pkt_byte;
        end else if (idx == `DPRX_IDX_COND) begin
            rd_mux = cond_q;
        end else if (idx == `DPRX_IDX_FIX2) begin
            rd_mux = fix2_q;
        end else if (idx == `DPRX_IDX_FRM) begin
            rd_mux = fm_rdata;
        end else if (idx == `DPRX_IDX_MODE) begin
            rd_mux = mode_q;
        end else if (idx == `DPRX_IDX_PTR_LO) begin
            rd_mux = fm_pkt[7:0];
        end else if (idx == `DPRX_IDX_PTR_HI) begin
            rd_mux = {7'h00, fm_pkt[8]};
        end else if (idx == `DPRX_IDX_PTR_BYTE) begin
            rd_mux = {2'h0, fm_byte};
        end else begin
            rd_mux = `DPRX_RST8;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !ack_q && !pwrite) begin
            prdata <= {24'h00_0000, rd_mux};
        end
    end

    // rd_done is kept for readability of the access strobes
    wire unused_rd;
    assign unused_rd = rd_done;
endmodule

/* inc/dprx_defines.vh */
// Constants for the demodulator packet receive port register bank
`ifndef DPRX_DEFINES_VH
`define DPRX_DEFINES_VH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define DPRX_IDX_STAT 6'h00
`define DPRX_IDX_MASK 6'h01
`define DPRX_IDX_BSEL 6'h02
`define DPRX_IDX_PKT 6'h03
`define DPRX_IDX_COND 6'h30
`define DPRX_IDX_FIX2 6'h37
`define DPRX_IDX_FRM 6'h38
`define DPRX_IDX_MODE 6'h39
`define DPRX_IDX_PTR_LO 6'h3b
`define DPRX_IDX_PTR_HI 6'h3c
`define DPRX_IDX_PTR_BYTE 6'h3d

// ----------------------------------------------------------------
// Flag register bits and masks
// ----------------------------------------------------------------
`define DPRX_B_REAL 0
`define DPRX_B_MAIN 1
`define DPRX_B_SYNC 2
`define DPRX_B_FRAME 4
`define DPRX_B_TMAIN 5
`define DPRX_B_TSUB 6
`define DPRX_B_SUB 7
`define DPRX_MASK_BITS 8'hf6
`define DPRX_MASK_BITS_HI 7'h7b
`define DPRX_RST8 8'h00

// ----------------------------------------------------------------
// Condition and access mode bits
// ----------------------------------------------------------------
`define DPRX_COND_GOOD 0
`define DPRX_COND_NOPAR 1
`define DPRX_COND_SI 2
`define DPRX_COND_PARTEST 3
`define DPRX_MODE_VERT 0
`define DPRX_MODE_PARITY 1

// ----------------------------------------------------------------
// Packet buffer layout
// ----------------------------------------------------------------
`define DPRX_PKT_DEPTH 36
`define DPRX_PKT_STAT1 6'd1
`define DPRX_PKT_LAST 6'd23
`define DPRX_PTR_RST 6'd0

// ----------------------------------------------------------------
// Frame timing and frame memory geometry
// ----------------------------------------------------------------
`define DPRX_FRAME_IRQ_PKT 9'd13
`define DPRX_FRAME_IRQ_TEST 9'd15
`define DPRX_FM_BYTE_LAST 6'd21
`define DPRX_FM_BYTE_LAST_PAR 6'd33
`define DPRX_FM_PKT_LAST 9'd189
`define DPRX_FM_PKT_LAST_PAR 9'd271

`endif

/* hw/dprx_pkt_ram.v */
// Small packet buffer with registered read data
`timescale 1ns/1ps
`include "dprx_defines.vh"
module dprx_pkt_ram (
    input wire pclk,
    input wire presetn,
    input wire we,
    input wire [5:0] waddr,
    input wire [7:0] wdata,
    input wire [5:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:`DPRX_PKT_DEPTH-1];

    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= `DPRX_RST8;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

/* hw/dprx_frame_ptr.v */
// Frame memory read pointer with horizontal or vertical stepping
`timescale 1ns/1ps
`include "dprx_defines.vh"
module dprx_frame_ptr (
    input wire pclk,
    input wire presetn,
    input wire ld_pkt_lo,
    input wire ld_pkt_hi,
    input wire ld_byte,
    input wire [7:0] wdata,
    input wire step,
    input wire vert,
    input wire parity,
    output reg [8:0] pkt_q,
    output reg [5:0] byte_q
);
    wire [5:0] byte_last;
    wire [8:0] pkt_last;
    wire byte_end;
    wire pkt_end;

    // Parity rows and columns widen the walk
    assign byte_last = parity ? `DPRX_FM_BYTE_LAST_PAR : `DPRX_FM_BYTE_LAST;
    assign pkt_last = parity ? `DPRX_FM_PKT_LAST_PAR : `DPRX_FM_PKT_LAST;
    assign byte_end = (byte_q >= byte_last);
    assign pkt_end = (pkt_q >= pkt_last);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_q <= 9'h000;
            byte_q <= `DPRX_PTR_RST;
        end else if (ld_pkt_lo) begin
            pkt_q <= {pkt_q[8], wdata};
        end else if (ld_pkt_hi) begin
            pkt_q <= {wdata[0], pkt_q[7:0]};
        end else if (ld_byte) begin
            byte_q <= wdata[5:0];
        end else if (step) begin
            // Position persists between reads, so bursts may pause
            if (vert) begin
                pkt_q <= pkt_end ? 9'h000 : pkt_q + 9'h001;
                if (pkt_end) begin
                    byte_q <= byte_end ? `DPRX_PTR_RST : byte_q + 6'h01;
                end
            end else begin
                byte_q <= byte_end ? `DPRX_PTR_RST : byte_q + 6'h01;
                if (byte_end) begin
                    pkt_q <= pkt_end ? 9'h000 : pkt_q + 9'h001;
                end
            end
        end
    end
endmodule

/* tb/dprx_chk_sva.sv */
// Bus and interrupt checks for the receive port bank
`timescale 1ns/1ps
`include "dprx_defines.vh"
module dprx_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq_n,
    input wire pkt_done,
    input wire pkt_done_sub,
    input wire frame_pkt_strobe,
    input wire frame_last,
    input wire vfix_start
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
reg [7:0] mask_q;
// Packet qualifiers off, so every main packet must interrupt
reg [2:0] cnd_q;
wire wr_done = psel && penable && pready && pwrite;
// Flag or mask writes may legally change the interrupt level
wire clr = wr_done && paddr[7:3] == 5'h00;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mask_q <= 8'h00;
        cnd_q <= 3'h0;
    end else if (wr_done && paddr[7:2] == `DPRX_IDX_MASK) begin
        mask_q <= pwdata[7:0] & `DPRX_MASK_BITS;
    end else if (wr_done && paddr[7:2] == `DPRX_IDX_COND) begin
        cnd_q <= pwdata[2:0];
    end
end
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
sequence s_setup;
    psel && !penable;
endsequence
sequence s_wait;
    psel && penable && !pready;
endsequence
property p_wait;
    s_setup ##1 s_wait |=> pready;
endproperty
property p_phase;
    pready |-> psel && penable;
endproperty
property p_err;
    pslverr |-> pready;
endproperty
property p_mask_rd;
    pready && !pwrite && paddr[7:2] == `DPRX_IDX_MASK |-> prdata == 32'h0;
endproperty
property p_irq_off;
    mask_q == 8'h00 ##1 mask_q == 8'h00 |-> irq_n;
endproperty
property p_irq_on;
    pkt_done && !pkt_done_sub && mask_q[1] && cnd_q == 3'h0 |=> !irq_n;
endproperty
property p_irq_hold;
    !irq_n && !clr |=> !irq_n;
endproperty
property p_vfix;
    vfix_start |-> $past(frame_pkt_strobe) && $past(frame_last);
endproperty
a_wait: assert property (p_wait) else $error("no answer after one wait");
a_phase: assert property (p_phase) else $error("ready outside access");
a_err: assert property (p_err) else $error("error without ready");
a_mask_rd: assert property (p_mask_rd) else $error("mask read not 0");
a_irq_off: assert property (p_irq_off) else $error("irq with mask 0");
a_irq_on: assert property (p_irq_on) else $error("irq not raised");
a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
a_vfix: assert property (p_vfix) else $error("stray vfix start");
endmodule

/* tb/dprx_host.sv */
// Bus master model of the host processor
`timescale 1ns/1ps
module dprx_host (
    input wire pclk,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [7:0] paddr,
    output reg [31:0] pwdata
);
initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
end
// Request held until ready is seen at an edge
task xfer(input w, input [5:0] a, input [7:0] v, output [7:0] r,
          output er);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench watchdog ends a wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep the old value
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    end
endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the receive port bank
`timescale 1ns/1ps
`include "dprx_defines.vh"
module testbench;
reg pclk = 1'b0;
reg presetn = 1'b0;
reg wen = 1'b0, wsub = 1'b0, done = 1'b0, dsub = 1'b0;
reg fs = 1'b0, ff = 1'b0, fl = 1'b0, vseen = 1'b0, fu = 1'b0;
reg [5:0] wa = 6'h00;
reg [7:0] wd = 8'h00, d;
reg [14:0] st = 15'h2d6d;
reg e;
integer n_fail = 0, n_tests = 0, i, j;
wire psel, penable, pwrite, pready, pslverr, irq_n, vfix_start, fm_we;
wire [7:0] paddr, fm_wdata;
wire [31:0] pwdata, prdata;
wire [14:0] fm_addr;
function [7:0] fmx(input [14:0] a);
    fmx = a[14:7] ^ a[7:0];
endfunction
function [7:0] pv(input s, input [5:0] k);
    pv = k == 6'd0 ? 8'hb6 : k == 6'd1 ? 8'ha6 : {s, 1'b1, k};
endfunction
wire [7:0] fm_rdata = fmx(fm_addr);
initial begin
    forever #12.5 pclk = ~pclk;
end
always @(posedge pclk) begin
    if (vfix_start === 1'b1) vseen <= 1'b1;
end
dprx_host dprx_host_inst (.pclk(pclk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
dprx_rx_port dprx_rx_port_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_n(irq_n), .pkt_wr_en(wen), .pkt_wr_sub(wsub), .pkt_wr_addr(wa),
    .pkt_wr_data(wd), .pkt_done(done), .pkt_done_sub(dsub),
    .post_fix_crc_error(st[0]), .fix_result_error(st[1]),
    .raw_crc_error(st[2]), .frame_lock_flag(st[3]),
    .block_lock_flag(st[4]), .block_id_found(st[5]),
    .block_id_hi(st[6]), .block_id_lo(st[7]),
    .traffic_service_flag(st[8]), .parity_packet(st[9]),
    .segment_boundary_flag(st[10]), .segment_index_hi(st[11]),
    .segment_index_lo(st[12]), .real_packet(st[13]), .si_match(st[14]),
    .timer_main_evt(1'b0), .timer_sub_evt(1'b0), .sync_lost_evt(1'b0),
    .frame_pkt_strobe(fs), .frame_first(ff), .frame_last(fl),
    .fix2_update(fu), .fix2_result(8'h5a), .vfix_start(vfix_start),
    .fm_addr(fm_addr), .fm_we(fm_we), .fm_wdata(fm_wdata),
    .fm_rdata(fm_rdata));
task chk(input string nm, input [7:0] x, input [7:0] g);
    begin
        n_tests = n_tests + 1;
        if (g !== x) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, x, g);
        end
    end
endtask
task rd(input [5:0] a, input [7:0] x);
    begin
        dprx_host_inst.xfer(1'b0, a, 8'h00, d, e);
        chk($sformatf("reg %h", a), x, d);
    end
endtask
task wr(input [5:0] a, input [7:0] v);
    dprx_host_inst.xfer(1'b1, a, v, d, e);
endtask
task pkt(input s);
    begin
        for (j = 2; j < 36; j = j + 1) begin
            @(posedge pclk);
            wen <= 1'b1;
            wsub <= s;
            wa <= j[5:0];
            wd <= {s, 1'b1, j[5:0]};
        end
        @(posedge pclk);
        wen <= 1'b0;
        done <= 1'b1;
        dsub <= s;
        @(posedge pclk);
        done <= 1'b0;
    end
endtask
task fr(input f, input l, input integer n);
    for (j = 0; j < n; j = j + 1) begin
        @(posedge pclk);
        fs <= 1'b1;
        ff <= f && j == 0;
        fl <= l && j == n - 1;
        @(posedge pclk);
        fs <= 1'b0;
    end
endtask
task close_out;
    begin
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end
endtask
initial begin
    #100000;
    n_fail = n_fail + 1;
    close_out;
end
initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    rd(`DPRX_IDX_STAT, 8'h00);
    rd(`DPRX_IDX_MASK, 8'h00);
    dprx_host_inst.xfer(1'b0, 6'h10, 8'h00, d, e);
    chk("unmapped err", 8'h01, {7'h00, e});
    pkt(1'b0);
    repeat (2) @(posedge pclk);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    wr(`DPRX_IDX_MASK, 8'h12);
    repeat (2) @(posedge pclk);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    rd(`DPRX_IDX_STAT, 8'h03);
    wr(`DPRX_IDX_BSEL, 8'h00);
    for (i = 0; i < 25; i = i + 1) begin
        rd(`DPRX_IDX_PKT, pv(1'b0, i > 23 ? 6'd23 : i[5:0]));
    end
    wr(`DPRX_IDX_STAT, 8'h02);
    repeat (2) @(posedge pclk);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    rd(`DPRX_IDX_STAT, 8'h00);
    pkt(1'b1);
    rd(`DPRX_IDX_STAT, 8'h80);
    wr(`DPRX_IDX_STAT, 8'h80);
    wr(`DPRX_IDX_BSEL, 8'h01);
    for (i = 0; i < 3; i = i + 1) begin
        rd(`DPRX_IDX_PKT, pv(1'b1, i[5:0]));
    end
    wr(`DPRX_IDX_BSEL, 8'h01);
    rd(`DPRX_IDX_PKT, 8'hb6);
    pkt(1'b0);
    rd(`DPRX_IDX_PKT, 8'hb6);
    wr(`DPRX_IDX_STAT, 8'h02);
    fr(1'b0, 1'b1, 1);
    repeat (3) @(posedge pclk);
    chk("vfix seen", 8'h00, {7'h00, vseen});
    fr(1'b1, 1'b0, 12);
    rd(`DPRX_IDX_STAT, 8'h00);
    fr(1'b0, 1'b0, 1);
    rd(`DPRX_IDX_STAT, 8'h10);
    wr(`DPRX_IDX_STAT, 8'h10);
    fr(1'b0, 1'b1, 1);
    repeat (3) @(posedge pclk);
    chk("vfix seen", 8'h01, {7'h00, vseen});
    wr(`DPRX_IDX_COND, 8'h08);
    fr(1'b1, 1'b0, 13);
    rd(`DPRX_IDX_STAT, 8'h00);
    fr(1'b0, 1'b0, 2);
    rd(`DPRX_IDX_STAT, 8'h10);
    wr(`DPRX_IDX_PTR_LO, 8'h05);
    wr(`DPRX_IDX_PTR_HI, 8'h00);
    wr(`DPRX_IDX_PTR_BYTE, 8'h03);
    wr(`DPRX_IDX_MODE, 8'h00);
    rd(`DPRX_IDX_FRM, fmx({9'd5, 6'd3}));
    rd(`DPRX_IDX_PTR_BYTE, 8'h04);
    wr(`DPRX_IDX_MODE, 8'h01);
    rd(`DPRX_IDX_FRM, fmx({9'd5, 6'd4}));
    rd(`DPRX_IDX_PTR_LO, 8'h06);
    wr(`DPRX_IDX_PTR_BYTE, 8'h15);
    wr(`DPRX_IDX_MODE, 8'h02);
    rd(`DPRX_IDX_FRM, fmx({9'd6, 6'd21}));
    rd(`DPRX_IDX_PTR_BYTE, 8'h16);
    @(posedge pclk) fu <= 1'b1;
    @(posedge pclk) fu <= 1'b0;
    rd(`DPRX_IDX_FIX2, 8'h5a);
    wr(`DPRX_IDX_STAT, 8'h10);
    wr(`DPRX_IDX_COND, 8'h01);
    pkt(1'b0);
    rd(`DPRX_IDX_STAT, 8'h00);
    wr(`DPRX_IDX_BSEL, 8'h00);
    rd(`DPRX_IDX_PKT, 8'hb6);
    rd(`DPRX_IDX_PKT, 8'h86);
    close_out;
end
endmodule
bind dprx_rx_port dprx_chk dprx_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_n(irq_n), .pkt_done(pkt_done), .pkt_done_sub(pkt_done_sub),
    .frame_pkt_strobe(frame_pkt_strobe), .frame_last(frame_last),
    .vfix_start(vfix_start));
